// File: design/asr_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides share one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module asr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0]   level;
    logic             doPush;
    logic             doPop;

    assign inReady  = (level != (PTR_W+1)'(DEPTH));
    assign outValid = (level != '0);
    assign outData  = mem[rdPtr];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            if (doPush && !doPop) begin
                level <= level + 1'b1;
            end else if (doPop && !doPush) begin
                level <= level - 1'b1;
            end
        end
    end

endmodule

// File: design/asr_readout.sv
// Conversion control and serial readout of a 16-bit sampling converter.
// Assumes the host drives strobe, shift clock and select; shift clock is
// a second domain that may stand still outside frames.
// Notes on behaviour
// - Strobe rise starts conversion, samples mode
// - Select low at strobe rise: chain
// - Select high at strobe rise: gated
// - Gated mode: drive output while strobe low, released after the last bit
// - Gated mode: strobe or select low enables
// - Result shifted out on shift clock
// - One bit advanced per shift clock
// - Chain mode: select acts as data in
// - Chain input reappears sixteen clocks later
// - Result ready within maximum conversion time
// - Top bit first, shown on enable
// - Output changes after falling shift edge
// - Straight binary, saturating at both ends
`timescale 1ns/100ps
module asr_readout
    import asr_pkg::*;
#(
    parameter bit FAST_VARIANT = 1'b0
) (
    // System clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Host pins
    input  wire logic                 sck,
    input  wire logic                 conversionStrobe,
    input  wire logic                 chainSelectIn,
    output asr_pkg::asr_pin_s         serialResultOut,
    // Converter core
    input  wire asr_pkg::asr_sample_s sampleIn,
    // Status
    output logic                      convBusy,
    output logic                      chainModeActive,
    output logic                      frameOverrun
);
    import asr_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_PUSH
    } asr_state_e;

    // Last index of the conversion counter for this variant
    localparam logic [7:0] CONV_LAST = (FAST_VARIANT != 1'b0)
        ? 8'(CONV_CYC_FAST - 1) : 8'(CONV_CYC_SLOW - 1);

    // Pin and frame-done synchronisers
    logic strobeMeta;
    logic strobeSync;
    logic strobePrev;
    logic selMeta;
    logic selSync;
    logic frameDoneMeta;
    logic frameDoneSync;

    // Conversion engine
    asr_state_e state;
    logic [7:0] convCount;
    asr_mode_e  mode;
    logic       strobeRise;
    logic [15:0] satCode;

    // Result path
    logic        pushValid;
    logic        pushReady;
    logic        popValid;
    logic        popReady;
    logic [15:0] popData;
    logic [15:0] holdWord;
    logic        linkClear;

    // Link domain
    logic [15:0] shiftReg;
    logic        firstBit;
    logic [4:0]  bitCount;
    logic        frameDone;
    logic        inBit;

    // Output drive
    logic outEn_n;

    // Two flip-flops on every pin read in the system domain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobeMeta <= 1'b0;
            strobeSync <= 1'b0;
            selMeta    <= 1'b1;
            selSync    <= 1'b1;
        end else begin
            strobeMeta <= conversionStrobe;
            strobeSync <= strobeMeta;
            selMeta    <= chainSelectIn;
            selSync    <= selMeta;
        end
    end

    // Frame completion level back from the link domain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frameDoneMeta <= 1'b0;
            frameDoneSync <= 1'b0;
        end else begin
            frameDoneMeta <= frameDone;
            frameDoneSync <= frameDoneMeta;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobePrev <= 1'b0;
        end else begin
            strobePrev <= strobeSync;
        end
    end

    assign strobeRise = strobeSync && !strobePrev;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode <= MODE_GATED;
        end else if (strobeRise && state == ST_IDLE) begin
            mode <= selSync ? MODE_GATED : MODE_CHAIN;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            convCount <= CONVCNT_RESET;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    convCount <= CONVCNT_RESET;
                    if (strobeRise) begin
                        state <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (convCount == CONV_LAST) begin
                        state <= ST_PUSH;
                    end else begin
                        convCount <= convCount + 1'b1;
                    end
                end
                ST_PUSH: begin
                    if (pushReady) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_comb begin
        if (sampleIn.overRange) begin
            satCode = CODE_FULL_SCALE;
        end else if (sampleIn.underRange) begin
            satCode = CODE_ZERO_SCALE;
        end else begin
            satCode = sampleIn.code;
        end
    end

    // Push waits here while the result queue is full
    assign pushValid = (state == ST_PUSH);

    // Draining stalls until a fresh frame is pending
    assign popReady = linkClear;

    asr_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) resultFifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (satCode),
        .outValid (popValid),
        .outReady (popReady),
        .outData  (popData)
    );

    // Held word is static while the link domain reads it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            holdWord <= HOLD_RESET;
        end else if (popValid && popReady) begin
            holdWord <= popData;
        end
    end

    // Link logic held cleared from strobe rise until result lands
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            linkClear <= 1'b1;
        end else if (strobeRise && state == ST_IDLE) begin
            linkClear <= 1'b1;
        end else if (popValid && popReady) begin
            linkClear <= 1'b0;
        end
    end

    // Next strobe before all bits clocked out
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frameOverrun <= 1'b0;
        end else if (strobeRise && !linkClear && !frameDoneSync) begin
            frameOverrun <= 1'b1;
        end else if (frameDoneSync) begin
            frameOverrun <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            convBusy        <= 1'b0;
            chainModeActive <= 1'b0;
        end else begin
            convBusy        <= (state != ST_IDLE);
            chainModeActive <= (mode == MODE_CHAIN);
        end
    end

    // select becomes data input in chain mode
    // Sampled only by sck flops, so it needs no synchroniser
    assign inBit = (mode == MODE_CHAIN) ? chainSelectIn : 1'b0;

    // Clear comes from a clk flop, so it cannot glitch
    // shift on each falling edge
    always_ff @(negedge sck or posedge linkClear) begin
        if (linkClear) begin
            shiftReg <= HOLD_RESET;
            firstBit <= 1'b1;
        end else begin
            firstBit <= 1'b0;
            if (firstBit) begin
                shiftReg <= {holdWord[14:0], inBit};
            end else begin
                shiftReg <= {shiftReg[14:0], inBit};
            end
        end
    end

    // Counts bits so gated output can release after the last one
    always_ff @(negedge sck or posedge linkClear) begin
        if (linkClear) begin
            bitCount  <= BITCNT_RESET;
            frameDone <= 1'b0;
        end else if (bitCount != 5'(CHAIN_DELAY)) begin
            bitCount  <= bitCount + 1'b1;
            frameDone <= (bitCount == 5'(CHAIN_DELAY - 1));
        end
    end

    // top bit shown before the first shift edge
    assign serialResultOut.data = firstBit ? holdWord[15] : shiftReg[15];

    // Frame end outranks the pin levels in gated mode
    // drive enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outEn_n <= 1'b1;
        end else if (mode == MODE_CHAIN) begin
            outEn_n <= 1'b0;
        end else if (frameDoneSync) begin
            outEn_n <= 1'b1;
        end else begin
            outEn_n <= !(!strobeSync || !selSync);
        end
    end

    assign serialResultOut.oe_n = outEn_n;

endmodule

// File: pkg/asr_pkg.sv
// Shared constants and carrier types for the serial readout chain.
// Assumes a 25 MHz system clock; the shift clock is a separate domain.
package asr_pkg;

    // Result word and chain geometry
    localparam int RESULT_W    = 16;
    localparam int CHAIN_DELAY = 16;
    localparam int FIFO_DEPTH  = 16;
    localparam int BITCNT_W    = 5;

    // System clock period
    localparam real CLK_PERIOD_NS = 40.0;

    // Longest conversion time of each variant, in microseconds
    localparam real CONV_TIME_SLOW_US = 9.5;
    localparam real CONV_TIME_FAST_US = 1.6;

    // Longest times round down, never below one cycle
    localparam int CONV_CYC_SLOW_RAW =
        int'($floor(CONV_TIME_SLOW_US * 1000.0 / CLK_PERIOD_NS));
    localparam int CONV_CYC_FAST_RAW =
        int'($floor(CONV_TIME_FAST_US * 1000.0 / CLK_PERIOD_NS));
    localparam int CONV_CYC_SLOW =
        (CONV_CYC_SLOW_RAW < 1) ? 1 : CONV_CYC_SLOW_RAW;
    localparam int CONV_CYC_FAST =
        (CONV_CYC_FAST_RAW < 1) ? 1 : CONV_CYC_FAST_RAW;
    localparam int CONV_CNT_W = 8;

    // Saturation codes
    localparam logic [15:0] CODE_FULL_SCALE = 16'hFFFF;
    localparam logic [15:0] CODE_ZERO_SCALE = 16'h0000;

    // Reset values
    localparam logic [15:0]       HOLD_RESET    = 16'h0000;
    localparam logic [4:0]        BITCNT_RESET  = 5'h00;
    localparam logic [7:0]        CONVCNT_RESET = 8'h00;

    typedef enum logic {
        MODE_GATED,
        MODE_CHAIN
    } asr_mode_e;

    // Raw result from the converter core
    typedef struct packed {
        logic        overRange;
        logic        underRange;
        logic [15:0] code;
    } asr_sample_s;

    // Serial output pin: value and active-low drive enable
    typedef struct packed {
        logic data;
        logic oe_n;
    } asr_pin_s;

endpackage

// File: verif/asr_host_model.sv
// Host model: strobe, select and a 15 ns shift clock within frames.
// Assumes strobe and select are timed off the system clock.
`timescale 1ns/100ps
module asr_host_model
    import asr_pkg::*;
#(
    parameter bit FAST_VARIANT = 1'b0
) (
    // System clock
    input  logic              clk,
    // Readout pins
    input  asr_pkg::asr_pin_s serialResultOut,
    output logic              sck,
    output logic              conversionStrobe,
    output logic              chainSelectIn
);
    import asr_pkg::*;
    initial begin
        sck = 1'b0;
        conversionStrobe = 1'b0;
        chainSelectIn = 1'b1;
    end
    // Set pin levels, then let them settle
    task automatic drive(input logic conversion_strobe, input logic sel);
        @(negedge clk);
        conversionStrobe = conversion_strobe;
        chainSelectIn = sel;
        repeat (5) @(negedge clk);
    endtask
    task automatic startConv(input logic sel);
        drive(1'b0, sel);
        @(negedge clk) conversionStrobe = 1'b1;
        repeat ((FAST_VARIANT ? CONV_CYC_FAST : CONV_CYC_SLOW) + 8)
            @(negedge clk);
    endtask
    task automatic shift(input int n, input logic chain,
                         input logic [31:0] din, output logic [31:0] got);
        got = '0;
        #3.3;
        for (int i = 0; i < n; i++) begin
            if (chain) chainSelectIn = din[31-i];
            #4.2 sck = 1'b1;
            got[n-1-i] = serialResultOut.data;
            #7.5 sck = 1'b0;
            #3.3;
        end
    endtask
endmodule

// File: verif/asr_readout_assertions.sv
// Port checks of the serial readout, bound onto its top module.
// Assumes one system clock and a synchronous active-low reset.
`timescale 1ns/100ps
module asr_readout_checker
    import asr_pkg::*;
#(
    parameter bit FAST_VARIANT = 1'b0
) (
    // Clock and reset
    input logic              clk,
    input logic              rst_n,
    // Host pins
    input logic              conversionStrobe,
    input logic              chainSelectIn,
    input asr_pkg::asr_pin_s serialResultOut,
    // Status
    input logic              convBusy,
    input logic              chainModeActive
);
    import asr_pkg::*;
    localparam int CONV_MAX =
        (FAST_VARIANT ? CONV_CYC_FAST : CONV_CYC_SLOW) + 6;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_start;
        $rose(conversionStrobe) && !convBusy |-> ##[2:5] convBusy;
    endproperty
    a_start: assert property (p_start)
        else $error("strobe rise started no conversion");
    property p_conv_time;
        $rose(convBusy) |-> ##[1:CONV_MAX] !convBusy;
    endproperty
    a_conv_time: assert property (p_conv_time)
        else $error("conversion too long");
    property p_chain_mode;
        $rose(convBusy) && !chainSelectIn && $past(chainSelectIn, 4)
            == chainSelectIn |=> chainModeActive;
    endproperty
    a_chain_mode: assert property (p_chain_mode)
        else $error("chain mode not taken");
    property p_gated_mode;
        $rose(convBusy) && chainSelectIn && $past(chainSelectIn, 4)
            == chainSelectIn |=> !chainModeActive;
    endproperty
    a_gated_mode: assert property (p_gated_mode)
        else $error("gated mode not taken");
    property p_chain_drive;
        $past(chainModeActive, 2) && chainModeActive && !convBusy
            |-> !serialResultOut.oe_n;
    endproperty
    a_chain_drive: assert property (p_chain_drive)
        else $error("chain output not driven");
    property p_gated_off;
        (!chainModeActive && conversionStrobe && chainSelectIn)[*5]
            |-> serialResultOut.oe_n;
    endproperty
    a_gated_off: assert property (p_gated_off)
        else $error("output driven while disabled");
    property p_strobe_en;
        $fell(conversionStrobe) && chainSelectIn && !chainModeActive
            && !convBusy |-> ##[1:5] !serialResultOut.oe_n;
    endproperty
    a_strobe_en: assert property (p_strobe_en)
        else $error("strobe low did not enable output");
    property p_select_en;
        $fell(chainSelectIn) && conversionStrobe && !chainModeActive
            && !convBusy |-> ##[1:5] !serialResultOut.oe_n;
    endproperty
    a_select_en: assert property (p_select_en)
        else $error("select low did not enable output");
endmodule

bind asr_readout asr_readout_checker #(.FAST_VARIANT(FAST_VARIANT)) chk (
    .clk, .rst_n, .conversionStrobe, .chainSelectIn, .serialResultOut,
    .convBusy, .chainModeActive
);

// File: verif/test_asr_readout.sv
// Self-checking bench of the serial readout driven by a host model.
// Assumes the slow variant and a 25 MHz system clock.
`timescale 1ns/100ps
module test_asr_readout;
    import asr_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        sck;
    logic        conversionStrobe;
    logic        chainSelectIn;
    asr_pin_s    serialResultOut;
    asr_sample_s sampleIn;
    logic        convBusy;
    logic        chainModeActive;
    logic        frameOverrun;
    logic [31:0] got;
    int          n_errors = 0;
    int          total_checks = 0;

    asr_readout uut (.clk, .rst_n, .sck, .conversionStrobe, .chainSelectIn,
        .serialResultOut, .sampleIn, .convBusy, .chainModeActive,
        .frameOverrun);
    asr_host_model host (.clk, .serialResultOut, .sck, .conversionStrobe,
        .chainSelectIn);

    initial clk = 1'b0;
    always #20 clk = ~clk;

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check1(input string what, input logic exp,
                          input logic seen);
        check(what, {31'h0, exp}, {31'h0, seen});
    endtask
    task automatic gated_read(input asr_sample_s smp, input logic [15:0] e);
        @(negedge clk) sampleIn = smp;
        host.startConv(1'b1);
        check1("busy", 1'b0, convBusy);
        check1("mode", 1'b0, chainModeActive);
        check1("no overrun", 1'b0, frameOverrun);
        host.drive(1'b0, 1'b1);
        check1("oe_n on", 1'b0, serialResultOut.oe_n);
        host.shift(16, 1'b0, 32'h0, got);
        check("word", {16'h0, e}, got);
        repeat (5) @(negedge clk);
        check1("oe_n off", 1'b1, serialResultOut.oe_n);
    endtask
    task automatic t_gated;
        gated_read({2'b00, 16'hA5C3}, 16'hA5C3);
        gated_read({2'b10, 16'h1234}, CODE_FULL_SCALE);
        gated_read({2'b01, 16'h1234}, CODE_ZERO_SCALE);
        $display("test gated done");
    endtask
    task automatic t_select;
        @(negedge clk) sampleIn = {2'b00, 16'h3C96};
        host.startConv(1'b1);
        check1("idle oe_n", 1'b1, serialResultOut.oe_n);
        host.drive(1'b1, 1'b0);
        check1("sel oe_n", 1'b0, serialResultOut.oe_n);
        host.shift(16, 1'b0, 32'h0, got);
        check("sel word", 32'h3C96, got);
        host.drive(1'b1, 1'b1);
        check1("rel oe_n", 1'b1, serialResultOut.oe_n);
        $display("test select done");
    endtask
    task automatic t_chain;
        @(negedge clk) sampleIn = {2'b00, 16'h5A3C};
        host.startConv(1'b0);
        check1("chain", 1'b1, chainModeActive);
        check1("chain oe_n", 1'b0, serialResultOut.oe_n);
        host.shift(32, 1'b1, 32'hC3A5_0000, got);
        check("chain word", 32'h5A3C_C3A5, got);
        $display("test chain done");
    endtask
    task automatic t_overrun;
        @(negedge clk) sampleIn = {2'b00, 16'h0F0F};
        host.startConv(1'b1);
        host.startConv(1'b1);
        check1("overrun", 1'b1, frameOverrun);
        host.drive(1'b0, 1'b1);
        host.shift(16, 1'b0, 32'h0, got);
        check("late word", 32'h0F0F, got);
        repeat (5) @(negedge clk);
        check1("overrun clr", 1'b0, frameOverrun);
        $display("test overrun done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        sampleIn = '0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        check1("reset oe_n", 1'b1, serialResultOut.oe_n);
        check1("reset busy", 1'b0, convBusy);
        t_gated();
        t_select();
        t_chain();
        t_overrun();
        complete_run();
    end
    initial begin
        repeat (10000) @(posedge clk);
        n_errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        complete_run();
    end
endmodule
